// ### common/cdsc_regs.vh
// register map, field positions, reset values and timing counts of the clock divider control
`ifndef CDSC_REGS_VH
`define CDSC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CDSC_ADDR_OUT_PD     8'h41
`define CDSC_ADDR_INPUT_CTL  8'h45
`define CDSC_ADDR_DIV_BASE   8'h4A
`define CDSC_ADDR_DIV_STEP   8'h02
`define CDSC_ADDR_PHASE_BASE 8'h4B
`define CDSC_ADDR_FUNCTION   8'h58
`define CDSC_ADDR_STATUS     8'h5A

// ----------------------------------------------------------------
// divider count register fields
// ----------------------------------------------------------------
`define CDSC_DIV_HI_LSB      0
`define CDSC_DIV_HI_MSB      3
`define CDSC_DIV_LO_LSB      4
`define CDSC_DIV_LO_MSB      7

// ----------------------------------------------------------------
// divider phase register fields
// ----------------------------------------------------------------
`define CDSC_PH_OFFSET_LSB   0
`define CDSC_PH_OFFSET_MSB   3
`define CDSC_PH_START_HIGH   4
`define CDSC_PH_NOSYNC       6
`define CDSC_PH_BYPASS       7

// ----------------------------------------------------------------
// input control and function register fields
// ----------------------------------------------------------------
`define CDSC_IN_SELECT_B     0
`define CDSC_IN_PD_A         1
`define CDSC_IN_PD_B         2
`define CDSC_FN_SOFT_SYNC    2
`define CDSC_FN_ROLE_LSB     5
`define CDSC_FN_ROLE_MSB     6

// ----------------------------------------------------------------
// pin role encodings
// ----------------------------------------------------------------
`define CDSC_ROLE_RESET      2'h0
`define CDSC_ROLE_SYNC       2'h1
`define CDSC_ROLE_RSVD       2'h2
`define CDSC_ROLE_PDOWN      2'h3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CDSC_RST_DIV         8'h00
`define CDSC_RST_PHASE       8'h00
`define CDSC_RST_FUNCTION    8'h00
`define CDSC_RST_INPUT_CTL   8'h00
`define CDSC_RST_OUT_PD      8'h00
`define CDSC_CHANNELS        5
`define CDSC_SYNC_STAGES     2

`endif

// ### src/cdsc_clock_control.v
// clock distribution control: input select, five dividers and multipurpose pin
//
// Behaviour
// - two-bit field picks multipurpose pin role
// - default role: pin low is hard reset
// - hard reset loads defaults, operation continues
// - pin release after reset issues sync
// - sync role realigns divider phases
// - sync only powered, unmasked, unbypassed outputs
// - sync low holds output at start level
// - after rise, start after phase-offset ticks
// - sync role has no reset or powerdown
// - sync behaviour active in every role
// - powerdown role: pin low powers chip down
// - release resumes with held settings, no defaults
// - selected fast input feeds all dividers
// - five outputs, independent divider each
// - bypass passes input, divider held idle
// - ratios 2 to 32, one by bypass
// - ratio, phase, duty configurable per divider
// - high count bits 3:0, low 7:4
`timescale 1ns/1ps
`include "cdsc_regs.vh"

module cdsc_clock_control (
  input  wire       clk,
  input  wire       rst,
  input  wire       fast_clock_input_a,
  input  wire       fast_clock_input_b,
  input  wire       functionPinLow,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  output wire       output_channel_0,
  output wire       output_channel_1,
  output wire       output_channel_2,
  output wire       output_channel_3,
  output wire       output_channel_4,
  output reg        chipPoweredDown
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [2:0] pinSync;         // synchronised {pin asserted, input b, input a}
  wire       fnPinLevel;      // multipurpose pin level, high is idle
  wire       inLevelA;        // fast input a level
  wire       inLevelB;        // fast input b level

  cdsc_sync2 #(
    .WIDTH   (3)
  ) u_pin_sync (
    .clk     (clk),
    .rst     (rst),
    // pin goes in inverted so that the cleared stages read as an idle high pin
    .asyncIn ({~functionPinLow, fast_clock_input_b, fast_clock_input_a}),
    .syncOut (pinSync)
  );

  assign inLevelA   = pinSync[0];
  assign inLevelB   = pinSync[1];
  assign fnPinLevel = ~pinSync[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] divCounts [0:4]; // high and low counts per divider
  reg  [7:0] divPhase  [0:4]; // phase, start level, mask, bypass
  reg  [7:0] functionReg;     // pin role and soft sync
  reg  [7:0] inputCtl;        // input select and input power-down
  reg  [7:0] outPowerDown;    // per-output power-down, bits 4:0
  reg        pinLevelLast;    // pin level one cycle ago
  reg        holdLast;        // sync hold one cycle ago
  reg        fastLevelLast;   // selected input one cycle ago

  wire [1:0] pinRole;         // decoded role field
  wire       pinLow;          // pin asserted low
  wire       hardReset;       // reset from pin or system reset
  wire       powerDownNow;    // pin asserted in powerdown role
  wire       syncHold;        // dividers held at start level
  wire       syncRelease;     // end of sync hold
  wire       selectB;         // input b chosen
  wire       selectedDown;    // chosen input is powered down
  wire       fastLevel;       // chosen input level
  wire       fastTick;        // one-cycle enable per fast rising edge
  wire [4:0] chanOut;         // divider outputs
  wire [4:0] chanHeld;        // channel currently held by sync
  wire [4:0] hitCounts;       // write address matches count register
  wire [4:0] hitPhase;        // write address matches phase register

  assign pinRole = functionReg[`CDSC_FN_ROLE_MSB:`CDSC_FN_ROLE_LSB];
  assign pinLow  = ~fnPinLevel;

  // hard reset only in the default role; sync and reserved roles do nothing here
  assign hardReset = rst || (pinLow && pinRole == `CDSC_ROLE_RESET);

  // full power-down only in the powerdown role
  assign powerDownNow = pinLow && pinRole == `CDSC_ROLE_PDOWN;

  // the pin holds dividers in every role; soft sync holds as well
  assign syncHold = pinLow || functionReg[`CDSC_FN_SOFT_SYNC];

  // release of the hold, also after a hard reset, restarts the dividers
  assign syncRelease = holdLast && !syncHold;

  // ----------------------------------------------------------------
  // fast clock selection
  // ----------------------------------------------------------------
  assign selectB      = inputCtl[`CDSC_IN_SELECT_B];
  assign selectedDown = selectB ? inputCtl[`CDSC_IN_PD_B] : inputCtl[`CDSC_IN_PD_A];
  // one chosen input feeds all dividers; a powered-down input gives no edges
  assign fastLevel    = selectedDown ? 1'b0 : (selectB ? inLevelB : inLevelA);
  assign fastTick     = fastLevel && !fastLevelLast && !chipPoweredDown;

  // ----------------------------------------------------------------
  // edge history and power-down state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pinLevelLast    <= 1'b0;
      holdLast        <= 1'b0;
      fastLevelLast   <= 1'b0;
      chipPoweredDown <= 1'b0;
    end else begin
      pinLevelLast    <= fnPinLevel;
      holdLast        <= syncHold;
      fastLevelLast   <= fastLevel;
      // down while the pin is low, back as soon as it returns high
      chipPoweredDown <= powerDownNow;
    end
  end

  // ----------------------------------------------------------------
  // register write address decode, one loop per channel
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `CDSC_CHANNELS; ch = ch + 1) begin : g_decode
      // this channel's two offsets, cut to the address width below
      localparam [31:0] COUNT_ADDR = `CDSC_ADDR_DIV_BASE + `CDSC_ADDR_DIV_STEP * ch;
      localparam [31:0] PHASE_ADDR = `CDSC_ADDR_PHASE_BASE + `CDSC_ADDR_DIV_STEP * ch;
      assign hitCounts[ch] = regWrite && (regAddr == COUNT_ADDR[7:0]);
      assign hitPhase[ch]  = regWrite && (regAddr == PHASE_ADDR[7:0]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes; a hard reset reloads every default
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk) begin
    if (hardReset) begin
      // defaults land in the live registers and are used at once
      for (i = 0; i < `CDSC_CHANNELS; i = i + 1) begin
        divCounts[i] <= `CDSC_RST_DIV;
        divPhase[i]  <= `CDSC_RST_PHASE;
      end
      functionReg  <= `CDSC_RST_FUNCTION;
      inputCtl     <= `CDSC_RST_INPUT_CTL;
      outPowerDown <= `CDSC_RST_OUT_PD;
    end else if (!chipPoweredDown) begin
      // settings are kept through power-down, never reloaded
      for (i = 0; i < `CDSC_CHANNELS; i = i + 1) begin
        if (hitCounts[i]) begin
          divCounts[i] <= regWdata;
        end
        if (hitPhase[i]) begin
          divPhase[i] <= regWdata;
        end
      end
      if (regWrite && regAddr == `CDSC_ADDR_FUNCTION) begin
        functionReg <= regWdata;
      end
      if (regWrite && regAddr == `CDSC_ADDR_INPUT_CTL) begin
        inputCtl <= regWdata;
      end
      if (regWrite && regAddr == `CDSC_ADDR_OUT_PD) begin
        outPowerDown <= regWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read, data in the cycle after the strobe
  // ----------------------------------------------------------------
  reg [7:0] next_regRdata; // read mux result
  integer   j;
  always @* begin
    next_regRdata = 8'h00;
    if (regAddr == `CDSC_ADDR_FUNCTION) begin
      next_regRdata = functionReg;
    end else if (regAddr == `CDSC_ADDR_INPUT_CTL) begin
      next_regRdata = inputCtl;
    end else if (regAddr == `CDSC_ADDR_OUT_PD) begin
      next_regRdata = {3'h0, outPowerDown[4:0]};
    end else if (regAddr == `CDSC_ADDR_STATUS) begin
      // live state: held channels, hold, power-down
      next_regRdata = {1'b0, chanHeld, syncHold, chipPoweredDown};
    end else begin
      for (j = 0; j < `CDSC_CHANNELS; j = j + 1) begin
        if (regAddr == `CDSC_ADDR_DIV_BASE + `CDSC_ADDR_DIV_STEP * j[7:0]) begin
          next_regRdata = divCounts[j];
        end
        if (regAddr == `CDSC_ADDR_PHASE_BASE + `CDSC_ADDR_DIV_STEP * j[7:0]) begin
          next_regRdata = divPhase[j];
        end
      end
    end
  end

  // read data register, zero when no read
  always @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= next_regRdata;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // five dividers, one per output
  // ----------------------------------------------------------------
  generate
    for (ch = 0; ch < `CDSC_CHANNELS; ch = ch + 1) begin : g_chan
      wire powered;   // channel and chip both powered
      wire bypassed;  // channel bypass bit
      wire syncable;  // channel takes part in sync

      assign powered  = !outPowerDown[ch] && !chipPoweredDown;
      assign bypassed = divPhase[ch][`CDSC_PH_BYPASS];
      // only powered, unmasked and unbypassed outputs are touched by sync
      assign syncable = powered && !divPhase[ch][`CDSC_PH_NOSYNC] && !bypassed;
      assign chanHeld[ch] = syncable && syncHold;

      cdsc_divider u_div (
        .clk         (clk),
        .rst         (hardReset),
        .fastTick    (fastTick),
        .fastLevel   (fastLevel),
        .powered     (powered),
        .bypass      (bypassed),
        .syncable    (syncable),
        .hold        (syncHold),
        .startHigh   (divPhase[ch][`CDSC_PH_START_HIGH]),
        .phaseOffset (divPhase[ch][`CDSC_PH_OFFSET_MSB:`CDSC_PH_OFFSET_LSB]),
        .highCount   (divCounts[ch][`CDSC_DIV_HI_MSB:`CDSC_DIV_HI_LSB]),
        .lowCount    (divCounts[ch][`CDSC_DIV_LO_MSB:`CDSC_DIV_LO_LSB]),
        .clkOut      (chanOut[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign output_channel_0 = chanOut[0];
  assign output_channel_1 = chanOut[1];
  assign output_channel_2 = chanOut[2];
  assign output_channel_3 = chanOut[3];
  assign output_channel_4 = chanOut[4];

endmodule

// ### src/cdsc_divider.v
// one output divider with bypass, phase offset, duty control and sync hold
`timescale 1ns/1ps

module cdsc_divider (
  input  wire       clk,
  input  wire       rst,
  input  wire       fastTick,
  input  wire       fastLevel,
  input  wire       powered,
  input  wire       bypass,
  input  wire       syncable,
  input  wire       hold,
  input  wire       startHigh,
  input  wire [3:0] phaseOffset,
  input  wire [3:0] highCount,
  input  wire [3:0] lowCount,
  output reg        clkOut
);

  reg [3:0] cycleCount;  // fast ticks spent in the present level
  reg [3:0] phaseWait;   // fast ticks still to wait after sync release
  reg       running;     // divider counting

  wire [3:0] levelLimit; // last count of the present level

  assign levelLimit = clkOut ? highCount : lowCount;

  // ----------------------------------------------------------------
  // divider state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      clkOut     <= 1'b0;
      cycleCount <= 4'h0;
      phaseWait  <= 4'h0;
      running    <= 1'b0;
    end else if (!powered) begin
      // powered down channel stays low and restarts from scratch
      clkOut     <= 1'b0;
      cycleCount <= 4'h0;
      running    <= 1'b0;
    end else if (bypass) begin
      // divider idle, output follows the fast clock
      clkOut     <= fastLevel;
      cycleCount <= 4'h0;
      running    <= 1'b0;
    end else if (hold && syncable) begin
      // held at the start level while sync is low
      clkOut     <= startHigh;
      cycleCount <= 4'h0;
      phaseWait  <= phaseOffset;
      running    <= 1'b0;
    end else if (fastTick) begin
      if (!running) begin
        // wait out the phase offset before counting
        if (phaseWait == 4'h0 || !syncable) begin
          running <= 1'b1;
        end else begin
          phaseWait <= phaseWait - 4'h1;
        end
      end else if (cycleCount == levelLimit) begin
        // level lasts count plus one ticks
        clkOut     <= ~clkOut;
        cycleCount <= 4'h0;
      end else begin
        cycleCount <= cycleCount + 4'h1;
      end
    end
  end

endmodule

// ### src/cdsc_sync2.v
// two flip-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps

module cdsc_sync2 #(
  parameter WIDTH = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;  // first stage, read only by the second

  // ----------------------------------------------------------------
  // two stages, nothing but the second one looks at the first one
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      stage1  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ### verif/cdsc_clock_control_monitor.sv
// port-level assertions for the clock distribution control block
`timescale 1ns/1ps

module cdsc_clock_control_monitor (
  input wire       clk,
  input wire       rst,
  input wire       functionPinLow,
  input wire [7:0] regAddr,
  input wire       regRead,
  input wire [7:0] regRdata,
  input wire       output_channel_0,
  input wire       output_channel_1,
  input wire       output_channel_2,
  input wire       output_channel_3,
  input wire       output_channel_4,
  input wire       chipPoweredDown
);
  // all five divider outputs as one word
  wire [4:0] outs = {output_channel_4, output_channel_3, output_channel_2, output_channel_1, output_channel_0};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  property p_rd_idle; !$past(regRead) |-> regRdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read answer");
  property p_rd_unmapped; regRead && regAddr == 8'h60 |=> regRdata == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_status;
    regRead && regAddr == 8'h5A ##1 $stable(chipPoweredDown) |-> regRdata[0] == chipPoweredDown;
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status bit0 differs from power-down");

  // ----------------------------------------------------------------
  // power-down and reset behaviour
  // ----------------------------------------------------------------
  property p_rst_clean; $fell(rst) |-> outs == 5'h00 && !chipPoweredDown && regRdata == 8'h00; endproperty
  a_rst_clean: assert property (p_rst_clean) else $error("outputs not cleared by reset");
  property p_pd_quiet; chipPoweredDown && $past(chipPoweredDown) |-> outs == 5'h00; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("outputs toggle while powered down");
  property p_pd_cause; $rose(chipPoweredDown) |-> !$past(functionPinLow); endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("power-down without pin low");
  property p_pd_hold; chipPoweredDown && !functionPinLow |=> chipPoweredDown; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("woke while pin still low");
  property p_pd_wake; chipPoweredDown && functionPinLow |-> ##[1:5] !chipPoweredDown; endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("no wake after pin high");
  property p_pd_wake_cause; $fell(chipPoweredDown) |-> $past(functionPinLow); endproperty
  a_pd_wake_cause: assert property (p_pd_wake_cause) else $error("woke without pin high");

  // main scenarios reached
  c_pd: cover property ($rose(chipPoweredDown));
  c_wake: cover property ($fell(chipPoweredDown));
  c_status: cover property (regRead && regAddr == 8'h5A);
endmodule

bind cdsc_clock_control cdsc_clock_control_monitor mon_u (
  .clk(clk), .rst(rst), .functionPinLow(functionPinLow), .regAddr(regAddr), .regRead(regRead),
  .regRdata(regRdata), .output_channel_0(output_channel_0), .output_channel_1(output_channel_1),
  .output_channel_2(output_channel_2), .output_channel_3(output_channel_3),
  .output_channel_4(output_channel_4), .chipPoweredDown(chipPoweredDown)
);

// ### verif/cdsc_pin_model.sv
// system controller model: two free-running fast clocks and the multipurpose pin
`timescale 1ns/1ps

module cdsc_pin_model (
  input  wire  clk,
  input  wire  pinReq,
  output logic fast_clock_input_a,
  output logic fast_clock_input_b,
  output logic functionPinLow
);
  logic [3:0] cntA;  // half period counter of input a, 4 cycles
  logic [3:0] cntB;  // half period counter of input b, 6 cycles

  initial begin
    cntA = 4'h0;
    cntB = 4'h0;
    fast_clock_input_a = 1'b0;
    fast_clock_input_b = 1'b0;
    functionPinLow = 1'b1;
  end

  // oscillators well below half the system rate; pin driven high unless asked low
  always @(posedge clk) begin
    cntA <= (cntA == 4'h3) ? 4'h0 : cntA + 4'h1;
    cntB <= (cntB == 4'h5) ? 4'h0 : cntB + 4'h1;
    if (cntA == 4'h3) fast_clock_input_a <= !fast_clock_input_a;
    if (cntB == 4'h5) fast_clock_input_b <= !fast_clock_input_b;
    functionPinLow <= !pinReq;
  end
endmodule

// ### verif/tb.sv
// self-checking bench for the clock distribution control block
`timescale 1ns/1ps

module tb;
  logic       clk;
  logic       rst;
  logic       pinReq;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  wire  [7:0] regRdata;
  wire        fastA;
  wire        fastB;
  wire        pinLow;
  wire        chipPoweredDown;
  wire  [4:0] outs;
  int         n_errors;
  int         checks;

  cdsc_pin_model pin_u (.clk(clk), .pinReq(pinReq), .fast_clock_input_a(fastA),
    .fast_clock_input_b(fastB), .functionPinLow(pinLow));

  cdsc_clock_control dut_u (.clk(clk), .rst(rst), .fast_clock_input_a(fastA), .fast_clock_input_b(fastB),
    .functionPinLow(pinLow), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .output_channel_0(outs[0]), .output_channel_1(outs[1]),
    .output_channel_2(outs[2]), .output_channel_3(outs[3]), .output_channel_4(outs[4]),
    .chipPoweredDown(chipPoweredDown));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    check($sformatf("register %h", a), {24'h0, regRdata}, {24'h0, exp});
  endtask

  // length in cycles of the next full run of level lvl on one channel
  task automatic runlen(input int ch, input logic lvl, output int n);
    int k;
    k = 0;
    n = 0;
    while (outs[ch] === lvl && k < 600) begin @(negedge clk); k++; end
    while (outs[ch] !== lvl && k < 600) begin @(negedge clk); k++; end
    while (outs[ch] === lvl && k < 600) begin @(negedge clk); k++; n++; end
  endtask

  task automatic chk_run(input int ch, input int hi, input int lo, input int tick);
    int n;
    runlen(ch, 1'b1, n);
    check($sformatf("high run ch%0d", ch), n, (hi + 1) * tick);
    runlen(ch, 1'b0, n);
    check($sformatf("low run ch%0d", ch), n, (lo + 1) * tick);
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    pinReq <= v;
  endtask

  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] tbl [5];
    logic [7:0] rv [7];
    int t2;
    int t3;
    tbl = '{8'h10, 8'h21, 8'h00, 8'h5A, 8'hFF};
    rv = '{8'h41, 8'h45, 8'h4A, 8'h4B, 8'h58, 8'h5A, 8'h60};
    rst = 1'b1;
    pinReq = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(rv[i], 8'h00);
    // independent ratio and duty per channel, ratios 2 and 32 included
    for (int i = 0; i < 5; i++) wr(8'(8'h4A + 2 * i), tbl[i]);
    for (int i = 0; i < 5; i++) begin
      rd(8'(8'h4A + 2 * i), tbl[i]);
      chk_run(i, tbl[i][3:0], tbl[i][7:4], 8);
    end
    // bypass follows the input clock
    wr(8'h4D, 8'h80);
    chk_run(1, 0, 0, 4);
    wr(8'h4D, 8'h00);
    // select input b, power down the unused one
    wr(8'h45, 8'h03);
    chk_run(0, 0, 1, 12);
    wr(8'h45, 8'h04);
    // sync role: ch0 masked, ch2/ch3 ratio 2 with offsets 0 and 2, ch4 starts high
    wr(8'h58, 8'h20);
    wr(8'h4B, 8'h40);
    wr(8'h50, 8'h00);
    wr(8'h51, 8'h02);
    wr(8'h53, 8'h10);
    pin(1'b1);
    repeat (10) @(negedge clk);
    check("held levels", {29'h0, outs[4:2]}, 32'h4);
    check("powered down", {31'h0, chipPoweredDown}, 32'h0);
    rd(8'h5A, 8'h7A);
    chk_run(0, 0, 1, 8);
    pin(1'b0);
    t2 = -1;
    t3 = -1;
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      if (outs[2] === 1'b1 && t2 < 0) t2 = k;
      if (outs[3] === 1'b1 && t3 < 0) t3 = k;
    end
    check("phase gap", t3 - t2, 16);
    rd(8'h4A, 8'h10);
    // reserved role: sync only
    wr(8'h58, 8'h40);
    pin(1'b1);
    repeat (10) @(negedge clk);
    rd(8'h5A, 8'h7A);
    pin(1'b0);
    repeat (10) @(posedge clk);
    rd(8'h4A, 8'h10);
    // power-down role: settings kept, writes while down ignored
    wr(8'h58, 8'h60);
    pin(1'b1);
    repeat (10) @(negedge clk);
    check("powered down", {31'h0, chipPoweredDown}, 32'h1);
    check("outputs down", {27'h0, outs}, 32'h0);
    wr(8'h4A, 8'h77);
    pin(1'b0);
    repeat (10) @(negedge clk);
    check("powered down", {31'h0, chipPoweredDown}, 32'h0);
    rd(8'h4A, 8'h10);
    rd(8'h58, 8'h60);
    // default role: hard reset reloads defaults, release restarts dividers
    wr(8'h58, 8'h00);
    pin(1'b1);
    repeat (10) @(posedge clk);
    pin(1'b0);
    repeat (10) @(posedge clk);
    rd(8'h4A, 8'h00);
    rd(8'h58, 8'h00);
    chk_run(0, 0, 0, 8);
    summarize();
  end
endmodule
